/* design/port_pins.sv */
module port_pins
  import power_rail_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_arst_n,
  input  wire logic [7:0] i_pad,
  port_ctrl_if.port       bus
);
  logic [7:0] pwm_count;
  logic [7:0] next_pwm_count;
  logic [7:0] pad_in;
  logic [7:0] next_pad_in;

  always_comb
  begin
    next_pwm_count = pwm_count + 8'h01;
    next_pad_in    = i_pad;
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pwm_count <= 8'h00;
      pad_in    <= 8'h00;
    end
    else
    begin
      pwm_count <= next_pwm_count;
      pad_in    <= next_pad_in;
    end
  end

  assign bus.pin_in = pad_in;

  for (genvar g = 0; g < PORT_WIDTH; g++)
  begin : g_pin
    logic drive_low;
    // Open-drain pins only ever pull low; in PIN_OD_PULLUP a high level comes from the pull-up, in PIN_OD_HIZ the pin floats
    assign drive_low = bus.pwm_en[g] ? (pwm_count >= bus.pwm_duty) : !bus.level[g];
    always_comb
    begin
      bus.pin_out[g]   = 1'b0;
      bus.pin_oe[g]    = 1'b0;
      bus.pullup_en[g] = 1'b0;
      if (bus.powered)
      begin
        case (bus.mode[g])
          PIN_PULLUP_IN: bus.pullup_en[g] = 1'b1;
          PIN_OD_PULLUP:
          begin
            bus.pullup_en[g] = !drive_low;
            bus.pin_oe[g]    = drive_low;
          end
          PIN_OD_HIZ:    bus.pin_oe[g] = drive_low;
          default:       bus.pin_oe[g] = 1'b0;
        endcase
      end
    end
  end
endmodule // port_pins

/* design/power_rail_control.sv */
// Behaviour
// - Emergency off drops selected running converters
// - Emergency off honoured only with rails regulated
// - Power request starts regulator then sequences rails
// - Request low turns regulator, rails, monitor and load switch off, standby
// - Adjustable rail set from 6-bit code
// - Boost is current regulator or voltage source
// - Voltage mode maps 6-bit boost code
// - Current monitor gain is 20 or 40
// - Eight port pins with PWM
// - Port pins default to Schmitt inputs
// - Five host-selectable pin configurations
// - Write address chosen by port pin zero
// - Address latched at port supply rise
// - Host enables adjustable, five-volt, boost, monitor
// - Load switch follows host command once running
// - Fault output signals host on faults
// - Fault output active low open drain
module power_rail_control
  import power_rail_pkg::*;
(
  // Clock and reset
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_arst_n,
  // Power control inputs
  input  wire logic                  i_power_on_request,
  input  wire logic                  i_emergency_off_n,
  input  wire logic                  i_core_rail_sense,
  input  wire logic [2:0]            i_rail_in_regulation,
  input  wire logic                  i_port_supply_ok,
  input  wire logic [7:0]            i_fault_status,
  // Host settings
  input  wire logic                  i_adj_enable,
  input  wire logic                  i_five_enable,
  input  wire logic                  i_boost_enable,
  input  wire logic                  i_monitor_enable,
  input  wire logic                  i_load_switch_on,
  input  wire logic [NUM_RAILS-1:0]  i_shutdown_select,
  input  wire logic [CODE_WIDTH-1:0] i_adj_code,
  input  wire logic                  i_boost_voltage_mode,
  input  wire logic [CODE_WIDTH-1:0] i_boost_code,
  input  wire logic                  i_monitor_gain_40,
  input  wire logic [23:0]           i_port_mode,
  input  wire logic [7:0]            i_port_level,
  input  wire logic [7:0]            i_port_pwm_en,
  input  wire logic [7:0]            i_port_pwm_duty,
  // Port pins
  input  wire logic [7:0]            i_port_pad,
  output logic      [7:0]            o_port_pad_out,
  output logic      [7:0]            o_port_pad_oe,
  output logic      [7:0]            o_port_pullup_en,
  output logic      [7:0]            o_port_pin_in,
  // Rail and block controls
  output logic                       o_internal_regulator_out,
  output logic      [NUM_RAILS-1:0]  o_rail_on,
  output logic                       o_monitor_on,
  output logic                       o_load_switch,
  output logic      [CODE_WIDTH-1:0] o_adj_code,
  output logic      [CODE_WIDTH-1:0] o_boost_code,
  output boost_mode_t                o_boost_mode,
  output amp_gain_t                  o_monitor_gain,
  output logic      [7:0]            o_write_address,
  output logic                       o_address_valid,
  // Fault output, open drain
  output logic                       o_fault_n_out,
  output logic                       o_fault_n_oe
);
  typedef enum {
    ST_STANDBY,
    ST_REG_UP,
    ST_SEQ_1,
    ST_SEQ_2,
    ST_SEQ_3,
    ST_SEQ_4,
    ST_RUN
  } seq_state_t;

  seq_state_t           state;
  seq_state_t           next_state;
  logic [3:0]           step_count;
  logic [3:0]           next_step_count;
  logic                 core_used;
  logic                 next_core_used;
  logic [3:0]           default_on;
  logic [3:0]           next_default_on;
  logic [NUM_RAILS-1:0] tripped;
  logic [NUM_RAILS-1:0] next_tripped;
  logic                 addr_high;
  logic                 next_addr_high;
  logic                 addr_valid;
  logic                 next_addr_valid;
  logic                 supply_seen;
  logic                 next_supply_seen;
  logic [NUM_RAILS-1:0] rail_on;
  logic                 step_done;
  logic                 emergency_active;

  port_ctrl_if port_bus ();

  assign step_done = (step_count == SEQ_STEP_LAST);
  // Unregulated rails could make a sagging supply look like a false trip
  assign emergency_active = !i_emergency_off_n && (&i_rail_in_regulation);

  always_comb
  begin
    next_state      = state;
    next_step_count = step_done ? 4'h0 : step_count + 4'h1;
    next_core_used  = core_used;
    next_default_on = default_on;
    next_tripped    = tripped;
    case (state)
      ST_STANDBY:
      begin
        next_step_count = 4'h0;
        if (i_power_on_request)
          next_state = ST_REG_UP;
      end
      ST_REG_UP:
        if (step_done)
        begin
          next_core_used = !i_core_rail_sense;
          next_state     = ST_SEQ_1;
        end
      // Without the core rail its slot stays empty, so the other rails keep their times
      ST_SEQ_1:
        if (step_done)
        begin
          next_default_on[RAIL_CORE] = core_used;
          next_state                 = ST_SEQ_2;
        end
      ST_SEQ_2:
        if (step_done)
        begin
          next_default_on[RAIL_MEM] = 1'b1;
          next_state                = ST_SEQ_3;
        end
      ST_SEQ_3:
        if (step_done)
        begin
          next_default_on[RAIL_IO] = 1'b1;
          next_state               = ST_SEQ_4;
        end
      ST_SEQ_4:
        if (step_done)
        begin
          next_default_on[RAIL_FIVE] = 1'b1;
          next_state                 = ST_RUN;
        end
      ST_RUN:    next_step_count = 4'h0;
      default:   next_state = ST_STANDBY;
    endcase
    // Trips stay until the request is dropped
    if (emergency_active)
      next_tripped = tripped | (i_shutdown_select & rail_on);
    if (!i_power_on_request)
    begin
      next_state      = ST_STANDBY;
      next_step_count = 4'h0;
      next_default_on = 4'h0;
      next_tripped    = '0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state      <= ST_STANDBY;
      step_count <= 4'h0;
      core_used  <= 1'b1;
      default_on <= 4'h0;
      tripped    <= '0;
    end
    else
    begin
      state      <= next_state;
      step_count <= next_step_count;
      core_used  <= next_core_used;
      default_on <= next_default_on;
      tripped    <= next_tripped;
    end
  end

  // Address strap is caught once per port supply rise
  always_comb
  begin
    next_supply_seen = i_port_supply_ok;
    next_addr_high   = addr_high;
    next_addr_valid  = addr_valid && i_port_supply_ok;
    if (i_port_supply_ok && !supply_seen)
    begin
      next_addr_high  = i_port_pad[0];
      next_addr_valid = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      supply_seen <= 1'b0;
      addr_high   <= 1'b0;
      addr_valid  <= 1'b0;
    end
    else
    begin
      supply_seen <= next_supply_seen;
      addr_high   <= next_addr_high;
      addr_valid  <= next_addr_valid;
    end
  end

  always_comb
  begin
    rail_on             = '0;
    rail_on[3:0]        = default_on;
    rail_on[RAIL_FIVE]  = default_on[RAIL_FIVE] && i_five_enable;
    rail_on[RAIL_ADJ]   = (state == ST_RUN) && i_adj_enable;
    rail_on[RAIL_BOOST] = (state == ST_RUN) && i_boost_enable;
    rail_on             = rail_on & ~tripped;
  end

  assign o_rail_on                = rail_on;
  assign o_internal_regulator_out = (state != ST_STANDBY);
  assign o_monitor_on             = (state == ST_RUN) && i_monitor_enable;
  assign o_load_switch            = (state == ST_RUN) && i_load_switch_on;
  assign o_adj_code               = i_adj_code;
  assign o_boost_code             = i_boost_code;
  assign o_boost_mode   = i_boost_voltage_mode ? BOOST_VOLTAGE : BOOST_CURRENT;
  assign o_monitor_gain = i_monitor_gain_40 ? GAIN_40 : GAIN_20;
  assign o_write_address = addr_high ? ADDR_PIN_HIGH : ADDR_PIN_LOW;
  assign o_address_valid = addr_valid;
  assign o_fault_n_out   = 1'b0;
  assign o_fault_n_oe    = |i_fault_status;

  // Unknown mode codes fall back to the Schmitt input default
  for (genvar g = 0; g < PORT_WIDTH; g++)
  begin : g_mode
    assign port_bus.mode[g] = (i_port_mode[3*g +: 3] > 3'(PIN_HIZ_OUT)) ? PIN_SCHMITT_IN
                              : pin_mode_t'(i_port_mode[3*g +: 3]);
  end
  assign port_bus.powered  = i_port_supply_ok;
  assign port_bus.level    = i_port_level;
  assign port_bus.pwm_en   = i_port_pwm_en;
  assign port_bus.pwm_duty = i_port_pwm_duty;

  port_pins u_port_pins (
    .i_sys_clk (i_sys_clk),
    .i_arst_n  (i_arst_n),
    .i_pad     (i_port_pad),
    .bus       (port_bus.port)
  );

  assign o_port_pad_out   = port_bus.pin_out;
  assign o_port_pad_oe    = port_bus.pin_oe;
  assign o_port_pullup_en = port_bus.pullup_en;
  assign o_port_pin_in    = port_bus.pin_in;
endmodule // power_rail_control

/* include/port_ctrl_if.sv */
interface port_ctrl_if;
  import power_rail_pkg::*;
  logic                  powered;
  pin_mode_t [7:0]       mode;
  logic      [7:0]       level;
  logic      [7:0]       pwm_en;
  logic      [7:0]       pwm_duty;
  logic      [7:0]       pin_in;
  logic      [7:0]       pin_out;
  logic      [7:0]       pin_oe;
  logic      [7:0]       pullup_en;
  modport ctrl (output powered, mode, level, pwm_en, pwm_duty, input pin_in,
                input pin_out, pin_oe, pullup_en);
  modport port (input powered, mode, level, pwm_en, pwm_duty, output pin_in,
                output pin_out, pin_oe, pullup_en);
endinterface

/* include/power_rail_pkg.sv */
package power_rail_pkg;
  // Rail indices for converter enables and shutdown selection
  localparam int RAIL_CORE    = 0;
  localparam int RAIL_MEM     = 1;
  localparam int RAIL_IO      = 2;
  localparam int RAIL_FIVE    = 3;
  localparam int RAIL_ADJ     = 4;
  localparam int RAIL_BOOST   = 5;
  localparam int NUM_RAILS    = 6;
  localparam int PORT_WIDTH   = 8;
  localparam int CODE_WIDTH   = 6;

  // Analog code figures, for reference by the bench
  localparam int ADJ_BASE_MV        = 3000;
  localparam int ADJ_STEP_UV        = 33300;
  localparam int BOOST_BASE_MV      = 12500;
  localparam int BOOST_STEP_MV      = 100;

  // Sequencing step time, in ns, and derived cycles at 10 MHz
  localparam int CLK_PERIOD_NS      = 100;
  localparam int SEQ_STEP_NS        = 1000;
  localparam int SEQ_STEP_CYC       = (SEQ_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] SEQ_STEP_LAST = 4'(SEQ_STEP_CYC - 1);

  // Bus write address choices
  localparam logic [7:0] ADDR_PIN_HIGH = 8'hCE;
  localparam logic [7:0] ADDR_PIN_LOW  = 8'h8E;

  // Reset values
  localparam logic [CODE_WIDTH-1:0] ADJ_CODE_RST   = 6'h00;
  localparam logic [CODE_WIDTH-1:0] BOOST_CODE_RST = 6'h00;

  // Port pin modes
  typedef enum logic [2:0] {
    PIN_SCHMITT_IN,
    PIN_PULLUP_IN,
    PIN_OD_PULLUP,
    PIN_OD_HIZ,
    PIN_HIZ_OUT
  } pin_mode_t;

  typedef enum logic {
    BOOST_CURRENT,
    BOOST_VOLTAGE
  } boost_mode_t;

  typedef enum logic {
    GAIN_20,
    GAIN_40
  } amp_gain_t;
endpackage

/* test/host_model.sv */
module host_model (
  // Clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_arst_n,
  // Fault line, pulled up
  input  wire logic i_fault_line,
  output int        o_services
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last;

  // One status read per new fault, so a held fault is not serviced twice
  always @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      last       <= 1'b1;
      o_services <= 0;
    end
    else
    begin
      last <= i_fault_line;
      if (last && !i_fault_line)
        o_services <= o_services + 1;
    end
  end
endmodule // host_model

/* test/power_rail_control_assertions.sv */
module power_rail_control_assertions
  import power_rail_pkg::*;
(
  // Block inputs
  input wire logic                  i_sys_clk,
  input wire logic                  i_arst_n,
  input wire logic                  i_power_on_request,
  input wire logic                  i_emergency_off_n,
  input wire logic [2:0]            i_rail_in_regulation,
  input wire logic [NUM_RAILS-1:0]  i_shutdown_select,
  input wire logic [7:0]            i_fault_status,
  input wire logic                  i_load_switch_on,
  input wire logic [CODE_WIDTH-1:0] i_adj_code,
  input wire logic [CODE_WIDTH-1:0] i_boost_code,
  input wire logic                  i_monitor_gain_40,
  // Block outputs
  input wire logic                  o_internal_regulator_out,
  input wire logic [NUM_RAILS-1:0]  o_rail_on,
  input wire logic                  o_load_switch,
  input wire logic [CODE_WIDTH-1:0] o_adj_code,
  input wire logic [CODE_WIDTH-1:0] o_boost_code,
  input wire amp_gain_t             o_monitor_gain,
  input wire logic [7:0]            o_write_address,
  input wire logic                  o_address_valid,
  input wire logic                  o_fault_n_out,
  input wire logic                  o_fault_n_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);

  chk_standby_all_off: assert property (!i_power_on_request |=>
    o_rail_on == '0 && !o_internal_regulator_out) else $error("rails left on in standby");
  chk_regulator_start: assert property ((i_power_on_request && !o_internal_regulator_out)
    |=> o_internal_regulator_out) else $error("regulator did not start");
  chk_emergency_drop: assert property ((!i_emergency_off_n
    && i_rail_in_regulation == 3'h7) |=> (o_rail_on & $past(i_shutdown_select)) == '0)
    else $error("selected rail not dropped");
  chk_emergency_ignored: assert property ((i_power_on_request && o_rail_on[RAIL_IO]
    && i_rail_in_regulation != 3'h7) |=> o_rail_on[RAIL_IO]) else $error("trip while unregulated");
  chk_fault_drive: assert property ((i_fault_status != 8'h00) |-> ##[0:1] o_fault_n_oe)
    else $error("fault not signalled");
  chk_fault_polarity: assert property (o_fault_n_oe |-> !o_fault_n_out)
    else $error("fault pin driven high");
  chk_code_pass: assert property (o_adj_code == i_adj_code
    && o_boost_code == i_boost_code) else $error("rail code mismatch");
  chk_gain_select: assert property (o_monitor_gain
    == (i_monitor_gain_40 ? GAIN_40 : GAIN_20)) else $error("gain mismatch");
  chk_switch_open: assert property ((!i_load_switch_on)[*2] |-> !o_load_switch)
    else $error("load switch closed without command");
  chk_address_hold: assert property ((o_address_valid && $past(o_address_valid))
    |-> $stable(o_write_address)) else $error("address changed while latched");
endmodule // power_rail_control_assertions

bind power_rail_control power_rail_control_assertions chk (.*);

/* test/power_rail_control_tb.sv */
`define CHK(nm, e, g) \
  begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end

module power_rail_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import power_rail_pkg::*;
  logic        i_sys_clk, i_arst_n, i_power_on_request, i_emergency_off_n, i_core_rail_sense;
  logic        i_port_supply_ok, i_adj_enable, i_five_enable, i_boost_enable, i_monitor_enable;
  logic        i_load_switch_on, i_boost_voltage_mode, i_monitor_gain_40;
  logic [2:0]  i_rail_in_regulation;
  logic [5:0]  i_shutdown_select, i_adj_code, i_boost_code, o_rail_on, o_adj_code, o_boost_code;
  logic [7:0]  i_fault_status, i_port_level, i_port_pwm_en, i_port_pwm_duty, i_port_pad;
  logic [7:0]  o_port_pad_out, o_port_pad_oe, o_port_pullup_en, o_port_pin_in, o_write_address;
  logic [23:0] i_port_mode;
  logic        o_internal_regulator_out, o_monitor_on, o_load_switch, o_address_valid;
  logic        o_fault_n_out, o_fault_n_oe;
  boost_mode_t o_boost_mode;
  amp_gain_t   o_monitor_gain;
  wire         fault_line;
  int          fail_count, num_checks, services, t, lows;

  power_rail_control dut (.*);
  host_model host (.i_sys_clk, .i_arst_n, .i_fault_line(fault_line), .o_services(services));
  assign fault_line = o_fault_n_oe ? o_fault_n_out : 1'b1;

  initial
  begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Cuts a hang short
  initial
  begin
    #5ms;
    fail_count++;
    stop_test();
  end

  initial
  begin
    {i_power_on_request, i_core_rail_sense, i_port_supply_ok, i_adj_enable} = '0;
    {i_boost_enable, i_monitor_enable, i_load_switch_on, i_boost_voltage_mode} = '0;
    {i_monitor_gain_40, i_arst_n, i_shutdown_select, i_fault_status} = '0;
    {i_adj_code, i_boost_code, i_port_mode, i_port_pwm_en, i_port_pwm_duty} = '0;
    {i_emergency_off_n, i_five_enable, i_rail_in_regulation} = 5'h1F;
    i_port_level = 8'h00;
    i_port_pad   = 8'h01;
    cyc(20);
    i_arst_n = 1'b1;
    cyc(1);
    `CHK("rails", 6'h00, o_rail_on)
    `CHK("pins", 8'h00, o_port_pad_oe | o_port_pullup_en)
    `CHK("pin_in", 8'h01, o_port_pin_in)
    i_port_supply_ok = 1'b1;
    cyc(2);
    `CHK("addr", {1'b1, ADDR_PIN_HIGH}, {o_address_valid, o_write_address})
    i_port_pad = 8'h00;
    cyc(2);
    `CHK("addr", ADDR_PIN_HIGH, o_write_address)
    `CHK("pin_in", 8'h00, o_port_pin_in)
    i_port_supply_ok = 1'b0;
    cyc(2);
    `CHK("addr_valid", 1'b0, o_address_valid)
    i_port_supply_ok = 1'b1;
    cyc(2);
    `CHK("addr", {1'b1, ADDR_PIN_LOW}, {o_address_valid, o_write_address})
    // Pull-up in pull-up input mode and while a PIN_OD_PULLUP pin is released; codes above 4 act as inputs
    for (int lv = 0; lv < 2; lv++)
    begin
      i_port_level = {8{lv[0]}};
      for (int m = 0; m < 8; m++)
      begin
        i_port_mode = 24'(m) << 3;
        cyc(1);
        `CHK("pullup", m == 1 || (m == 2 && lv == 1), o_port_pullup_en[1])
        `CHK("drive", (m == 2 || m == 3) && lv == 0, o_port_pad_oe[1])
        `CHK("pad_out", 8'h00, o_port_pad_out)
      end
    end
    // Full PWM period, so the counter phase does not matter
    i_port_mode     = 24'h000018;
    i_port_level    = 8'hFF;
    i_port_pwm_en   = 8'h02;
    i_port_pwm_duty = 8'h40;
    cyc(2);
    lows = 0;
    repeat (256)
    begin
      cyc(1);
      lows += int'(o_port_pad_oe[1]);
    end
    `CHK("pwm", 192, lows)
    `CHK("pad_out", 8'h00, o_port_pad_out)
    i_port_pwm_en = 8'h00;
    i_power_on_request = 1'b1;
    cyc(1);
    `CHK("regulator", 1'b1, o_internal_regulator_out)
    t = 1;
    for (int k = 0; k < 4; k++)
    begin
      cyc(1 + (k + 2) * SEQ_STEP_CYC - 1 - t);
      `CHK("early", 1'b0, o_rail_on[k])
      cyc(1);
      `CHK("rail", 1'b1, o_rail_on[k])
      t = 1 + (k + 2) * SEQ_STEP_CYC;
    end
    {i_adj_enable, i_boost_enable, i_monitor_enable, i_load_switch_on} = 4'hF;
    cyc(2);
    `CHK("run", 4'hF, {o_rail_on[5:4], o_monitor_on, o_load_switch})
    {i_adj_enable, i_boost_enable, i_monitor_enable, i_load_switch_on} = 4'h0;
    cyc(2);
    `CHK("run", 4'h0, {o_rail_on[5:4], o_monitor_on, o_load_switch})
    {i_adj_enable, i_boost_enable} = 2'h3;
    for (int c = 0; c < 64; c += 21)
    begin
      i_adj_code           = 6'(c);
      i_boost_code         = 6'(63 - c);
      i_boost_voltage_mode = c[0];
      i_monitor_gain_40    = ~c[0];
      cyc(1);
      `CHK("adj", 6'(c), o_adj_code)
      `CHK("boost", 6'(63 - c), o_boost_code)
      `CHK("mode", c[0] ? BOOST_VOLTAGE : BOOST_CURRENT, o_boost_mode)
      `CHK("gain", c[0] ? GAIN_20 : GAIN_40, o_monitor_gain)
    end
    i_rail_in_regulation = 3'h3;
    i_shutdown_select    = 6'h3F;
    i_emergency_off_n    = 1'b0;
    cyc(2);
    `CHK("ignored", 6'h3F, o_rail_on)
    i_rail_in_regulation = 3'h7;
    i_emergency_off_n    = 1'b1;
    i_shutdown_select    = 6'h12;
    cyc(1);
    i_emergency_off_n = 1'b0;
    cyc(1);
    `CHK("trip", 6'h2D, o_rail_on)
    i_emergency_off_n = 1'b1;
    i_fault_status    = 8'h80;
    cyc(3);
    `CHK("fault", 1'b0, fault_line)
    `CHK("serviced", 1, services)
    i_fault_status = 8'h00;
    cyc(2);
    `CHK("fault", 1'b1, fault_line)
    i_power_on_request = 1'b0;
    cyc(1);
    `CHK("standby", 9'h000, {o_internal_regulator_out, o_rail_on, o_monitor_on, o_load_switch})
    i_core_rail_sense  = 1'b1;
    i_power_on_request = 1'b1;
    cyc(2 + 5 * SEQ_STEP_CYC);
    `CHK("coreless", 4'hE, o_rail_on[3:0])
    stop_test();
  end
endmodule // power_rail_control_tb
